/* cdr_defs.svh */
// constants for the diagnostic receive handler
`ifndef CDR_DEFS_SVH
`define CDR_DEFS_SVH
`define CDR_ADDR_CTRL      8'h00
`define CDR_ADDR_PAT_VAL   8'h04
`define CDR_ADDR_PAT_CARE  8'h08
`define CDR_ADDR_TMO       8'h0c
`define CDR_ADDR_STATUS    8'h10
`define CDR_ADDR_FRAME     8'h14
`define CDR_ADDR_INFO      8'h18
`define CDR_ADDR_DATA_LO   8'h1c
`define CDR_ADDR_DATA_HI   8'h20
`define CDR_ADDR_COUNT     8'h24
`define CDR_ADDR_PEND_OPT  8'h28
`define CDR_CTRL_RESTORE   0
`define CDR_CTRL_AUTOFMT   1
`define CDR_CTRL_HEADERS   2
`define CDR_CTRL_SPLIT     3
`define CDR_CTRL_ISO       4
`define CDR_CTRL_ARM       5
`define CDR_CTRL_RESET     5'h0a
`define CDR_PEND_EXT_BIT   2
`define CDR_PEND_ISO_BIT   0
`define CDR_PEND_RESET     8'h04
`define CDR_PAT_VAL_RESET  29'h000007e8
`define CDR_PAT_CARE_RESET 29'h000007f8
`define CDR_PAT_EXT_RESET  1'b0
`define CDR_PCI_FIRST      4'h1
`define CDR_PCI_CONSEC     4'h2
`define CDR_NEG_RESP       8'h7f
`define CDR_PENDING_CODE   8'h78
`define CDR_PEND_TIME_S    5
`define CDR_CLK_HZ         200000000
`define CDR_PEND_CYCLES    (`CDR_PEND_TIME_S * `CDR_CLK_HZ)
`define CDR_TMO_RESET      32'h05f5e100
`endif

/* cdr_pkg.sv */
// types for the diagnostic receive handler
package cdr_pkg;
    typedef enum logic [2:0] {
        CDR_IDLE    = 3'b001,
        CDR_WAIT    = 3'b010,
        CDR_PENDING = 3'b100
    } cdr_wait_t;
    typedef enum logic [1:0] {
        CDR_KIND_SINGLE = 2'h0,
        CDR_KIND_FIRST  = 2'h1,
        CDR_KIND_CONSEC = 2'h2,
        CDR_KIND_OTHER  = 2'h3
    } cdr_kind_t;
endpackage : cdr_pkg

/* cdr_id_match.sv */
// per-bit identifier acceptance compare
`timescale 1ns/1ps
`default_nettype none
module cdr_id_match (
    input  wire logic [28:0] id_i,
    input  wire logic        id_ext_i,
    input  wire logic [28:0] pat_val_i,
    input  wire logic [28:0] pat_care_i,
    input  wire logic        pat_ext_i,
    output logic             accept_o
);
    logic [28:0] bit_ok;
    genvar g;
    generate
        for (g = 0; g < 29; g++) begin : g_bit
            assign bit_ok[g] = ~pat_care_i[g] | (pat_val_i[g] == id_i[g]);
        end
    endgenerate
    // short ids only look at the low 11 bits; the pattern width must match the frame
    wire short_ok = &bit_ok[10:0];
    wire long_ok  = &bit_ok;
    assign accept_o = (id_ext_i == pat_ext_i) & (id_ext_i ? long_ok : short_ok);
endmodule // cdr_id_match
`default_nettype wire

/* cdr_rx_handler.sv */
// diagnostic can receive handler with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "cdr_defs.svh"
module cdr_rx_handler #(
    parameter logic [31:0] PEND_CYCLES = `CDR_PEND_CYCLES
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [7:0]       paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic             rx_valid_i,
    input  wire logic [28:0]      rx_id_i,
    input  wire logic             rx_ext_i,
    input  wire logic [63:0]      rx_data_i,
    input  wire logic             rx_iso_i,
    output logic                  timeout_o,
    output logic                  frame_kept_o,
    output cdr_pkg::cdr_kind_t    frame_kind_o
);
    import cdr_pkg::*;

    logic [4:0]  ctrl_ff;
    logic [28:0] pat_val_ff;
    logic [28:0] pat_care_ff;
    logic        pat_ext_ff;
    logic [31:0] tmo_cfg_ff;
    logic [7:0]  pend_opt_ff;
    logic [7:0]  service_ff;
    logic [31:0] count_ff;
    logic [31:0] kept_cnt_ff;
    logic [28:0] f_id_ff;
    logic        f_ext_ff;
    logic [63:0] f_data_ff;
    logic [1:0]  f_kind_ff;
    logic [3:0]  f_seg_ff;
    logic [11:0] f_len_ff;
    logic        f_new_ff;
    logic        f_kept_ff;
    logic        f_pend_ff;
    logic        timeout_ff;
    cdr_wait_t   wait_ff;
    cdr_wait_t   nxt_wait;
    logic [31:0] nxt_count;

    wire wr_en = psel_i & penable_i & pwrite_i;
    wire rd_en = psel_i & penable_i & ~pwrite_i;
    wire sel_ctrl  = paddr_i == `CDR_ADDR_CTRL;
    wire sel_val   = paddr_i == `CDR_ADDR_PAT_VAL;
    wire sel_care  = paddr_i == `CDR_ADDR_PAT_CARE;
    wire sel_tmo   = paddr_i == `CDR_ADDR_TMO;
    wire sel_stat  = paddr_i == `CDR_ADDR_STATUS;
    wire sel_frame = paddr_i == `CDR_ADDR_FRAME;
    wire sel_info  = paddr_i == `CDR_ADDR_INFO;
    wire sel_dlo   = paddr_i == `CDR_ADDR_DATA_LO;
    wire sel_dhi   = paddr_i == `CDR_ADDR_DATA_HI;
    wire sel_cnt   = paddr_i == `CDR_ADDR_COUNT;
    wire sel_pend  = paddr_i == `CDR_ADDR_PEND_OPT;
    wire mapped = sel_ctrl | sel_val | sel_care | sel_tmo | sel_stat | sel_frame
                | sel_info | sel_dlo | sel_dhi | sel_cnt | sel_pend;
    wire restore = wr_en & sel_ctrl & pwdata_i[`CDR_CTRL_RESTORE];

    // every frame is classified; the filter alone decides keeping
    wire id_accept;
    cdr_id_match u_match (
        .id_i       (rx_id_i),
        .id_ext_i   (rx_ext_i),
        .pat_val_i  (pat_val_ff),
        .pat_care_i (pat_care_ff),
        .pat_ext_i  (pat_ext_ff),
        .accept_o   (id_accept)
    );

    wire [7:0] pci      = rx_data_i[63:56];
    wire [1:0] kind     = (pci[7:4] == `CDR_PCI_FIRST)  ? 2'(CDR_KIND_FIRST)  :
                          (pci[7:4] == `CDR_PCI_CONSEC) ? 2'(CDR_KIND_CONSEC) :
                          (pci[7:4] == 4'h0)            ? 2'(CDR_KIND_SINGLE) :
                                                          2'(CDR_KIND_OTHER);
    wire [7:0] pay0 = (kind == 2'(CDR_KIND_FIRST)) ? rx_data_i[47:40] : rx_data_i[55:48];
    wire [7:0] pay1 = (kind == 2'(CDR_KIND_FIRST)) ? rx_data_i[39:32] : rx_data_i[47:40];
    wire [7:0] pay2 = (kind == 2'(CDR_KIND_FIRST)) ? rx_data_i[31:24] : rx_data_i[39:32];
    // matches any service when none was recorded; one ecu state only
    wire is_pend = (pay0 == `CDR_NEG_RESP) & (pay2 == `CDR_PENDING_CODE)
                 & ((service_ff == 8'h00) | (pay1 == service_ff));
    wire kept = rx_valid_i & id_accept;
    wire ext_allowed = pend_opt_ff[`CDR_PEND_EXT_BIT]
                     & (~pend_opt_ff[`CDR_PEND_ISO_BIT] | rx_iso_i);
    wire pend_hit  = kept & is_pend & ext_allowed;
    wire reply_hit = kept & ~is_pend;
    wire armed = wr_en & sel_ctrl & pwdata_i[`CDR_CTRL_ARM];

    always_comb begin
        nxt_wait  = wait_ff;
        nxt_count = count_ff;
        unique case (wait_ff)
            CDR_IDLE: begin
                if (armed) begin
                    nxt_wait  = CDR_WAIT;
                    nxt_count = tmo_cfg_ff;
                end
            end
            CDR_WAIT, CDR_PENDING: begin
                if (pend_hit) begin
                    nxt_wait  = CDR_PENDING;
                    nxt_count = PEND_CYCLES;
                end else if (reply_hit) begin
                    nxt_wait  = CDR_IDLE;
                    nxt_count = tmo_cfg_ff;
                end else if (count_ff <= 32'h1) begin
                    nxt_wait  = CDR_IDLE;
                    nxt_count = tmo_cfg_ff;
                end else begin
                    nxt_count = count_ff - 32'h1;
                end
            end
            default: begin
                nxt_wait  = CDR_IDLE;
                nxt_count = tmo_cfg_ff;
            end
        endcase
    end

    wire expire = (wait_ff != CDR_IDLE) & ~pend_hit & ~reply_hit & (count_ff <= 32'h1);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_ff     <= `CDR_CTRL_RESET;
            pat_val_ff  <= `CDR_PAT_VAL_RESET;
            pat_care_ff <= `CDR_PAT_CARE_RESET;
            pat_ext_ff  <= `CDR_PAT_EXT_RESET;
            tmo_cfg_ff  <= `CDR_TMO_RESET;
            pend_opt_ff <= `CDR_PEND_RESET;
        end else if (restore) begin
            ctrl_ff     <= `CDR_CTRL_RESET;
            pat_val_ff  <= `CDR_PAT_VAL_RESET;
            pat_care_ff <= `CDR_PAT_CARE_RESET;
            pat_ext_ff  <= `CDR_PAT_EXT_RESET;
            pend_opt_ff <= `CDR_PEND_RESET;
        end else if (wr_en) begin
            if (sel_ctrl) ctrl_ff <= {pwdata_i[`CDR_CTRL_ISO:`CDR_CTRL_AUTOFMT], 1'b0};
            // care bits come from the host expanding x digits to cleared nibbles
            if (sel_val) begin
                pat_val_ff <= pwdata_i[28:0];
                pat_ext_ff <= pwdata_i[31];
            end
            if (sel_care) pat_care_ff <= pwdata_i[28:0];
            if (sel_tmo) tmo_cfg_ff <= pwdata_i;
            if (sel_pend) pend_opt_ff <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_ff    <= CDR_IDLE;
            count_ff   <= `CDR_TMO_RESET;
            timeout_ff <= 1'b0;
            service_ff <= 8'h00;
        end else begin
            wait_ff    <= nxt_wait;
            count_ff   <= nxt_count;
            timeout_ff <= expire | (timeout_ff & ~armed); // set wins over clear
            if (armed) service_ff <= pwdata_i[15:8];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            f_id_ff     <= 29'h0;
            f_ext_ff    <= 1'b0;
            f_data_ff   <= 64'h0;
            f_kind_ff   <= 2'h0;
            f_seg_ff    <= 4'h0;
            f_len_ff    <= 12'h0;
            f_new_ff    <= 1'b0;
            f_kept_ff   <= 1'b0;
            f_pend_ff   <= 1'b0;
            kept_cnt_ff <= 32'h0;
        end else begin
            f_kept_ff <= kept;
            if (kept) begin
                f_id_ff   <= rx_id_i;
                f_ext_ff  <= rx_ext_i;
                f_data_ff <= rx_data_i;
                f_kind_ff <= kind;
                f_seg_ff  <= (kind == 2'(CDR_KIND_CONSEC)) ? pci[3:0] : 4'h0;
                if (kind == 2'(CDR_KIND_FIRST)) f_len_ff <= {pci[3:0], rx_data_i[55:48]};
                f_pend_ff   <= is_pend;
                kept_cnt_ff <= kept_cnt_ff + 32'h1;
            end
            // new-frame flag: set wins over the read that clears it
            f_new_ff <= kept | (f_new_ff & ~(rd_en & sel_dhi));
        end
    end

    // shown id: raw bytes, or priority digit and 18 bit pgn when split is on and the stored id is extended
    wire split = ctrl_ff[`CDR_CTRL_SPLIT] & f_ext_ff;
    wire [31:0] shown_id = split ? {1'b0, f_id_ff[28:26], 10'h0, f_id_ff[25:8]}
                                 : {3'h0, f_id_ff};
    wire hdr_on  = ctrl_ff[`CDR_CTRL_HEADERS];
    wire strip   = ctrl_ff[`CDR_CTRL_AUTOFMT] & ~hdr_on;
    wire [63:0] shown_data = strip ? ((f_kind_ff == 2'(CDR_KIND_FIRST)) ? {f_data_ff[47:0], 16'h0}
                                                                        : {f_data_ff[55:0], 8'h0})
                                   : f_data_ff;
    // length line precedes frame lines when formatting a first frame
    wire len_line = ctrl_ff[`CDR_CTRL_AUTOFMT] & (f_kind_ff == 2'(CDR_KIND_FIRST));
    wire [31:0] info = {f_len_ff, 8'h0, 3'h0, len_line, f_seg_ff, f_pend_ff, f_new_ff, f_kind_ff};
    wire [31:0] status = {27'h0, timeout_ff, wait_ff, f_new_ff};

    wire [31:0] rd_mux = sel_ctrl  ? {27'h0, ctrl_ff} :
                         sel_val   ? {pat_ext_ff, 2'h0, pat_val_ff} :
                         sel_care  ? {3'h0, pat_care_ff} :
                         sel_tmo   ? tmo_cfg_ff :
                         sel_stat  ? status :
                         sel_frame ? shown_id :
                         sel_info  ? info :
                         sel_dlo   ? shown_data[31:0] :
                         sel_dhi   ? shown_data[63:32] :
                         sel_cnt   ? kept_cnt_ff :
                         sel_pend  ? {24'h0, pend_opt_ff} : 32'h0;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    assign pready_o     = 1'b1;
    assign pslverr_o    = psel_i & penable_i & ~mapped;
    assign timeout_o    = timeout_ff;
    assign frame_kept_o = f_kept_ff;
    assign frame_kind_o = cdr_kind_t'(f_kind_ff);
endmodule // cdr_rx_handler
`default_nettype wire

/* cdr_rx_handler_sva.sv */
// assertion checker for the diagnostic receive handler
`timescale 1ns/1ps
`default_nettype none
`include "cdr_defs.svh"
module cdr_rx_handler_sva #(
    parameter logic [31:0] PEND_CYCLES = `CDR_PEND_CYCLES
) (
    input wire logic               clock_i,
    input wire logic               resetn_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic               pwrite_i,
    input wire logic [7:0]         paddr_i,
    input wire logic [31:0]        pwdata_i,
    input wire logic [31:0]        prdata_o,
    input wire logic               pready_o,
    input wire logic               pslverr_o,
    input wire logic               rx_valid_i,
    input wire logic [28:0]        rx_id_i,
    input wire logic               rx_ext_i,
    input wire logic [63:0]        rx_data_i,
    input wire logic               rx_iso_i,
    input wire logic               timeout_o,
    input wire logic               frame_kept_o,
    input wire cdr_pkg::cdr_kind_t frame_kind_o
);
    import cdr_pkg::*;
    // shadow of the acceptance pattern, followed from bus writes
    logic [28:0] val_ff;
    logic [28:0] care_ff;
    logic        ext_ff;
    wire         wr  = psel_i & penable_i & pwrite_i;
    wire         rst = wr && paddr_i == `CDR_ADDR_CTRL && pwdata_i[`CDR_CTRL_RESTORE];
    // short ids carry only 11 meaningful bits
    wire         acc = ((rx_id_i ^ val_ff) & care_ff & (rx_ext_i ? 29'h1fffffff : 29'h000007ff)) == 29'h0
                       && rx_ext_i == ext_ff;
    wire         bad = paddr_i > `CDR_ADDR_PEND_OPT || paddr_i[1:0] != 2'h0;
    wire [3:0]   pci = rx_data_i[63:60];
    cdr_kind_t   ek;
    assign ek = pci == `CDR_PCI_FIRST ? CDR_KIND_FIRST : pci == `CDR_PCI_CONSEC ? CDR_KIND_CONSEC :
                pci == 4'h0 ? CDR_KIND_SINGLE : CDR_KIND_OTHER;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            val_ff  <= `CDR_PAT_VAL_RESET;
            care_ff <= `CDR_PAT_CARE_RESET;
            ext_ff  <= `CDR_PAT_EXT_RESET;
        end else if (rst) begin
            val_ff  <= `CDR_PAT_VAL_RESET;
            care_ff <= `CDR_PAT_CARE_RESET;
            ext_ff  <= `CDR_PAT_EXT_RESET;
        end else if (wr && paddr_i == `CDR_ADDR_PAT_VAL) begin
            val_ff <= pwdata_i[28:0];
            ext_ff <= pwdata_i[31];
        end else if (wr && paddr_i == `CDR_ADDR_PAT_CARE) begin
            care_ff <= pwdata_i[28:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    AST_READY: assert property (pready_o) else $error("pready low");
    AST_ERR: assert property (pslverr_o == (psel_i && penable_i && bad)) else $error("slverr wrong");
    AST_RD0: assert property (psel_i && penable_i && !pwrite_i && bad |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    AST_KEEP: assert property (rx_valid_i && acc |=> frame_kept_o) else $error("frame lost");
    AST_DROP: assert property (rx_valid_i && !acc |=> !frame_kept_o) else $error("frame not dropped");
    AST_KIND: assert property (rx_valid_i && acc |=> frame_kind_o == $past(ek)) else $error("kind wrong");
    AST_KHOLD: assert property (!frame_kept_o |-> $stable(frame_kind_o)) else $error("kind moved");
    AST_ARM: assert property (wr && paddr_i == 8'h00 && pwdata_i[5] |=> !timeout_o [*2])
        else $error("timeout kept over arm");
endmodule // cdr_rx_handler_sva
`default_nettype wire

/* cdr_ecu_model.sv */
// control units on the diagnostic bus, one frame per call
`timescale 1ns/1ps
`default_nettype none
module cdr_ecu_model (
    input  wire logic        clock_i,
    output logic             rx_valid_o,
    output logic [28:0]      rx_id_o,
    output logic             rx_ext_o,
    output logic [63:0]      rx_data_o,
    output logic             rx_iso_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_id_o    = 29'h0;
        rx_ext_o   = 1'b0;
        rx_data_o  = 64'h0;
        rx_iso_o   = 1'b0;
    end
    task automatic send(input logic [28:0] id, input logic ext, input logic [63:0] d, input logic iso);
        @(posedge clock_i);
        rx_valid_o <= 1'b1;
        rx_id_o    <= id;
        rx_ext_o   <= ext;
        rx_data_o  <= d;
        rx_iso_o   <= iso;
        @(posedge clock_i);
        // stale lines are inverted so a reused value cannot pass unseen
        rx_valid_o <= 1'b0;
        rx_id_o    <= ~id;
        rx_ext_o   <= ~ext;
        rx_data_o  <= ~d;
        rx_iso_o   <= ~iso;
    endtask
endmodule // cdr_ecu_model
`default_nettype wire

/* cdr_rx_handler_test.sv */
// self-checking bench for the diagnostic receive handler
`timescale 1ns/1ps
`default_nettype none
module cdr_rx_handler_test;
    import cdr_pkg::*;
    localparam logic [31:0] PEND = 32'd20;
    localparam logic [63:0] PND  = 64'h037f227800000000;
    logic        clock_i   = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] rd;
    logic [31:0] prdata_o;
    logic        err, pready_o, pslverr_o, rx_valid_i, rx_ext_i, rx_iso_i, timeout_o, frame_kept_o;
    logic [28:0] rx_id_i;
    logic [63:0] rx_data_i;
    cdr_kind_t   frame_kind_o;
    int          miscompares = 0;
    int          compares = 0;
    int          n;
    cdr_rx_handler #(.PEND_CYCLES(PEND)) u_cdr_rx_handler (.*);
    cdr_ecu_model u_cdr_ecu_model (.clock_i(clock_i), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i),
        .rx_ext_o(rx_ext_i), .rx_data_o(rx_data_i), .rx_iso_o(rx_iso_i));
    initial forever #2.5 clock_i = ~clock_i;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        for (k = 0; pready_o !== 1'b1; k++) begin
            if (k == 50) begin
                miscompares++;
                finish_test;
            end
            @(posedge clock_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic st(input logic [2:0] exp);
        apb(1'b0, 8'h10, 32'h0);
        check({29'h0, rd[3:1]}, {29'h0, exp});
    endtask
    task automatic fr(input logic [28:0] id, input logic ext, input logic [63:0] d, input logic iso, input logic k);
        u_cdr_ecu_model.send(id, ext, d, iso);
        #1;
        check({31'h0, frame_kept_o}, {31'h0, k});
    endtask
    task automatic t_def;
        rdchk(8'h00, 32'h0a);
        rdchk(8'h04, 32'h7e8);
        rdchk(8'h08, 32'h7f8);
        rdchk(8'h0c, 32'h05f5e100);
        rdchk(8'h28, 32'h04);
        rdchk(8'h2c, 32'h0);
        check({31'h0, err}, 32'h1);
        fr(29'h7e9, 1'b0, 64'h064100be3fb81300, 1'b1, 1'b1);
        fr(29'h7e0, 1'b0, 64'h064100be3fb81300, 1'b1, 1'b0);
        fr(29'h7e8, 1'b1, 64'h064100be3fb81300, 1'b1, 1'b0);
    endtask
    task automatic t_kind;
        fr(29'h7e8, 1'b0, 64'h1013490401353630, 1'b1, 1'b1);
        check({30'h0, frame_kind_o}, {30'h0, CDR_KIND_FIRST});
        apb(1'b0, 8'h18, 32'h0);
        check({19'h0, rd[31:20], rd[8]}, {19'h0, 12'h013, 1'b1});
        fr(29'h7e8, 1'b0, 64'h2132383934394143, 1'b1, 1'b1);
        check({30'h0, frame_kind_o}, {30'h0, CDR_KIND_CONSEC});
        apb(1'b0, 8'h18, 32'h0);
        check({28'h0, rd[7:4]}, 32'h1);
        // four pids asked, answered out of the asked order
        fr(29'h7e8, 1'b0, 64'h100a410b21043f0c, 1'b1, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        check({20'h0, rd[31:20]}, 32'h00a);
        fr(29'h7e8, 1'b0, 64'h2117b80544000000, 1'b1, 1'b1);
        // only the four counted bytes sit in the high word; the low word is padding
        rdchk(8'h20, 32'h17b80544);
        fr(29'h7e9, 1'b0, 64'h3000000000000000, 1'b1, 1'b1);
        check({30'h0, frame_kind_o}, {30'h0, CDR_KIND_OTHER});
        rdchk(8'h24, 32'h6);
    endtask
    task automatic t_pat;
        apb(1'b1, 8'h04, 32'h7e9);
        apb(1'b1, 8'h08, 32'h7ff);
        fr(29'h7e9, 1'b0, 64'h0, 1'b1, 1'b1);
        fr(29'h7e8, 1'b0, 64'h0, 1'b1, 1'b0);
        apb(1'b1, 8'h04, 32'h98fef500);
        apb(1'b1, 8'h08, 32'h1fffff00);
        fr(29'h18fef510, 1'b1, 64'h064100be3fb81300, 1'b0, 1'b1);
        fr(29'h18fef610, 1'b1, 64'h0, 1'b0, 1'b0);
        fr(29'h7e8, 1'b0, 64'h0, 1'b0, 1'b0);
        rdchk(8'h14, 32'h6000fef5);
        apb(1'b1, 8'h00, 32'h02);
        fr(29'h18fef5a3, 1'b1, 64'h064100be3fb81300, 1'b0, 1'b1);
        rdchk(8'h14, 32'h18fef5a3);
        rdchk(8'h20, 32'h4100be3f);
        apb(1'b1, 8'h00, 32'h06);
        fr(29'h18fef5a3, 1'b1, 64'h064100be3fb81300, 1'b0, 1'b1);
        rdchk(8'h20, 32'h064100be);
        apb(1'b1, 8'h00, 32'h0b);
        fr(29'h7ea, 1'b0, 64'h0, 1'b0, 1'b1);
    endtask
    task automatic t_pend;
        apb(1'b1, 8'h0c, 32'd100);
        apb(1'b1, 8'h00, 32'h222a);
        st(3'b010);
        fr(29'h7e8, 1'b0, PND, 1'b1, 1'b1);
        st(3'b100);
        repeat (10) @(posedge clock_i);
        fr(29'h7e9, 1'b0, PND, 1'b1, 1'b1);
        repeat (15) @(posedge clock_i);
        #1;
        check({31'h0, timeout_o}, 32'h0);
        for (n = 0; n < 12 && timeout_o !== 1'b1; n++) begin
            @(posedge clock_i);
            #1;
        end
        check({31'h0, timeout_o}, 32'h1);
        apb(1'b1, 8'h00, 32'h222a);
        fr(29'h7e8, 1'b0, PND, 1'b1, 1'b1);
        fr(29'h7e8, 1'b0, 64'h0362220100000000, 1'b1, 1'b1);
        st(3'b001);
        repeat (30) @(posedge clock_i);
        #1;
        check({31'h0, timeout_o}, 32'h0);
        apb(1'b1, 8'h28, 32'h05);
        apb(1'b1, 8'h00, 32'h222a);
        fr(29'h7e8, 1'b0, PND, 1'b0, 1'b1);
        // pending reply off iso is not taken: the normal wait keeps running
        st(3'b010);
        apb(1'b1, 8'h28, 32'h00);
        apb(1'b1, 8'h00, 32'h222a);
        fr(29'h7e8, 1'b0, PND, 1'b1, 1'b1);
        st(3'b010);
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, rd[3]}, 32'h1);
    endtask
    initial begin
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_def();
        t_kind();
        t_pat();
        t_pend();
        finish_test();
    end
endmodule // cdr_rx_handler_test
bind cdr_rx_handler cdr_rx_handler_sva #(.PEND_CYCLES(PEND_CYCLES)) u_cdr_rx_handler_sva (.*);
`default_nettype wire
